// >>> core/fsei_params.svh
// Constants for the frame stamp and endpoint index block
`ifndef FSEI_PARAMS_SVH
`define FSEI_PARAMS_SVH

// ==========================================
// Register indices (byte address = 4 * index)
`define FSEI_IDX_EPSEL 6'h0a
`define FSEI_IDX_FNLOW 6'h0e
`define FSEI_IDX_FCHIGH 6'h0f
`define FSEI_IDX_CTRL 6'h10
`define FSEI_IDX_STAT 6'h11
`define FSEI_IDX_MASK 6'h12

// ==========================================
// Field positions in frame_control_high
`define FSEI_B_VALID 7
`define FSEI_B_FLAG 6
`define FSEI_B_IRQEN 5
`define FSEI_B_LOCK 4
`define FSEI_B_PINDIS 3

// Field positions in the control register
`define FSEI_B_FEAT 0
`define FSEI_B_HOLD 1
`define FSEI_B_CHAN 2

// ==========================================
// Reset values and timing
`define FSEI_RST8 8'h00
`define FSEI_RST3 3'h0
`define FSEI_CLK_MHZ 100
`define FSEI_FRAME_US 1000
`define FSEI_PULSE_CYC 4'h8
`define FSEI_LOCK_TOL 17'h0_0040

`endif

// >>> core/fsei_pkg.sv
// Types shared by the frame stamp and endpoint index block
package fsei_pkg;

	// ==========================================
	// Start-of-frame token from the serial engine
	typedef struct packed {
		logic valid;
		logic [10:0] number;
	} fsei_sof_type;

	// ==========================================
	// Frame timer state
	typedef enum logic [0:0] {
		FT_IDLE = 1'b0,
		FT_RUN = 1'b1
	} fsei_state_type;

	// ==========================================
	// Local control bits
	typedef struct packed {
		logic chan_en;
		logic write_hold;
		logic feature_mode;
	} fsei_ctrl_type;

endpackage

// >>> core/fsei_top.sv
// Frame stamp tracking and endpoint index selection with Wishbone slave
`timescale 1ns/1ps
`include "fsei_params.svh"

// Functional notes
// (RQ1) Stamp valid set on good token, cleared artificially
// (RQ2) Frame flag set on every new frame
// (RQ3) Firmware write one acts as hardware set
// (RQ4) Flag self-clears unless pin-disable or feature set
// (RQ5) Frame interrupt needs flag, enable, channel enable
// (RQ6) Interrupt enable is software-owned only
// (RQ7) Lock bit shows frame timer lock state
// (RQ8) Pin held high while output disabled
// (RQ9) Each flag set gives eight-cycle low pulse
// (RQ10) Upper three number bits in high register
// (RQ11) Lower eight number bits in low register
// (RQ12) Artificial frame keeps stored number unchanged
// (RQ13) Firmware holds write-hold flag for protected bits
// (RQ14) Three-bit index selects endpoint zero to seven
// (RQ15) Reserved index bits read zero, written zero
// (RQ16) Firmware keeps index during receive read sets
// (RQ17) Reset clears both frame registers and index
// (RQ18) Missing token gives artificial frame at boundary

module fsei_top
	import fsei_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = `FSEI_FRAME_US * `FSEI_CLK_MHZ
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Token side from the serial engine
	input wire fsei_sof_type sof_i,
	// Frame outputs
	output logic frame_start_pin_n_o,
	output logic frame_irq_o,
	output logic irq_o,
	// Endpoint selection
	output logic [2:0] endpoint_index_field_o
);

	// ==========================================
	// Declarations
	localparam logic [16:0] PERIOD_LAST = 17'(FRAME_CYCLES - 1);

	logic [5:0] idx;
	logic req;
	logic wr_take;
	logic rd_take;
	logic ack_reg;
	logic [7:0] rd_next;
	logic [7:0] dat_reg;

	fsei_state_type ft_reg;
	logic [16:0] tmr_reg;
	logic locked_reg;
	logic sof_ev;
	logic art_ev;

	logic [2:0] ts_high_reg;
	logic [7:0] ts_low_reg;
	logic valid_reg;
	logic flag_reg;
	logic irq_en_reg;
	logic pin_dis_reg;
	fsei_ctrl_type ctrl_reg;
	logic [2:0] ep_reg;

	logic fw_set1;
	logic fw_clr;
	logic fs_set;
	logic self_clr;
	logic hold_wr;
	logic pin_dis_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic pin_reg;
	logic [2:0] ev;
	logic [2:0] stat_reg;
	logic [2:0] mask_reg;

	// Address decode, reused by every register
	function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
		return a == r;
	endfunction

	// ==========================================
	// Wishbone slave
	assign idx = adr_i[7:2];
	assign req = cyc_i & stb_i;

	// One wait cycle, then a single-cycle ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	assign ack_o = ack_reg;
	// Writes land only at the edge the master sees ack
	assign wr_take = req & ack_reg & we_i & sel_i[0];
	assign rd_take = req & ack_reg & ~we_i;
	assign hold_wr = wr_take & hit(idx, `FSEI_IDX_FCHIGH) & ctrl_reg.write_hold;

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_next = `FSEI_RST8;
		case (idx)
			`FSEI_IDX_EPSEL: begin
				rd_next = {5'h0_0, ep_reg}; // [RQ15]
			end
			`FSEI_IDX_FNLOW: begin
				rd_next = ts_low_reg;
			end
			`FSEI_IDX_FCHIGH: begin
				rd_next = {valid_reg, flag_reg, irq_en_reg, locked_reg,
					pin_dis_reg, ts_high_reg}; // [RQ7]
			end
			`FSEI_IDX_CTRL: begin
				rd_next = {5'h0_0, ctrl_reg};
			end
			`FSEI_IDX_STAT: begin
				rd_next = {5'h0_0, stat_reg};
			end
			`FSEI_IDX_MASK: begin
				rd_next = {5'h0_0, mask_reg};
			end
			default: begin
				rd_next = `FSEI_RST8;
			end
		endcase
	end

	// Read data captured in the wait cycle, held through ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= `FSEI_RST8;
		end else if (req & ~ack_reg) begin
			dat_reg <= rd_next;
		end
	end

	assign dat_o = {24'h00_0000, dat_reg};

	// ==========================================
	// Frame timer
	assign sof_ev = sof_i.valid;
	// No artificial frame before the first real token
	assign art_ev = (ft_reg == FT_RUN) & ~sof_ev & (tmr_reg == PERIOD_LAST); // [RQ18]

	// Timer state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ft_reg <= FT_IDLE;
		end else begin
			case (ft_reg)
				FT_IDLE: begin
					if (sof_ev) begin
						ft_reg <= FT_RUN;
					end
				end
				FT_RUN: begin
					ft_reg <= FT_RUN;
				end
				default: begin
					ft_reg <= FT_IDLE;
				end
			endcase
		end
	end

	// Frame period counter restarts on every frame start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tmr_reg <= 17'h0_0000;
		end else if (sof_ev | art_ev) begin
			tmr_reg <= 17'h0_0000; // [RQ18]
		end else if (ft_reg == FT_RUN) begin
			tmr_reg <= 17'(tmr_reg + 17'h0_0001);
		end
	end

	// Lock: a token near the predicted boundary locks, a miss unlocks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			locked_reg <= 1'b0;
		end else if (art_ev) begin
			locked_reg <= 1'b0; // [RQ7]
		end else if (sof_ev) begin
			locked_reg <= (ft_reg == FT_RUN) &&
				(tmr_reg >= 17'(PERIOD_LAST - `FSEI_LOCK_TOL)); // [RQ7]
		end
	end

	// ==========================================
	// Frame number store
	// Artificial frames leave the number for firmware to fix
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ts_high_reg <= `FSEI_RST3; // [RQ17]
			ts_low_reg <= `FSEI_RST8; // [RQ17]
		end else if (sof_ev) begin // [RQ12]
			ts_high_reg <= sof_i.number[10:8]; // [RQ10]
			ts_low_reg <= sof_i.number[7:0]; // [RQ11]
		end else begin
			if (wr_take & hit(idx, `FSEI_IDX_FCHIGH)) begin
				ts_high_reg <= dat_i[2:0];
			end
			if (wr_take & hit(idx, `FSEI_IDX_FNLOW)) begin
				ts_low_reg <= dat_i[7:0];
			end
		end
	end

	// Stamp valid is hardware-owned; writes do not reach it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_reg <= 1'b0;
		end else if (sof_ev) begin
			valid_reg <= 1'b1; // [RQ1]
		end else if (art_ev) begin
			valid_reg <= 1'b0; // [RQ1]
		end
	end

	// ==========================================
	// Frame-start flag
	assign fw_set1 = wr_take & hit(idx, `FSEI_IDX_FCHIGH) & dat_i[`FSEI_B_FLAG];
	assign fw_clr = wr_take & hit(idx, `FSEI_IDX_FCHIGH) & ~dat_i[`FSEI_B_FLAG];
	// Firmware set shares the hardware path, pin and interrupt alike
	assign fs_set = sof_ev | art_ev | fw_set1; // [RQ2] [RQ3]
	assign self_clr = ~pin_dis_reg & ~ctrl_reg.feature_mode;

	// A new set wins over any clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= 1'b0;
		end else if (fs_set) begin
			flag_reg <= 1'b1; // [RQ2] [RQ3]
		end else if (fw_clr | self_clr) begin
			flag_reg <= 1'b0; // [RQ4]
		end
	end

	// Protected bits change only with the write-hold flag set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_reg <= 1'b0;
			pin_dis_reg <= 1'b0;
		end else if (hold_wr) begin
			irq_en_reg <= dat_i[`FSEI_B_IRQEN]; // [RQ6] [RQ13]
			pin_dis_reg <= dat_i[`FSEI_B_PINDIS]; // [RQ13]
		end
	end
	assign pin_dis_next = hold_wr ? dat_i[`FSEI_B_PINDIS] : pin_dis_reg; // [RQ8] no glitch

	// ==========================================
	// Local control and endpoint index
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= `FSEI_RST3;
		end else if (wr_take & hit(idx, `FSEI_IDX_CTRL)) begin
			ctrl_reg <= dat_i[2:0];
		end
	end

	// Index is not guarded against mid-read changes; firmware owns that
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ep_reg <= `FSEI_RST3; // [RQ17]
		end else if (wr_take & hit(idx, `FSEI_IDX_EPSEL)) begin
			ep_reg <= dat_i[2:0]; // [RQ14] [RQ16]
		end
	end

	assign endpoint_index_field_o = ep_reg; // [RQ14]

	// ==========================================
	// Frame-start pin pulse
	always_comb begin
		cnt_next = cnt_reg;
		if (fs_set & ~pin_dis_next) begin
			cnt_next = `FSEI_PULSE_CYC; // [RQ9]
		end else if (cnt_reg != 4'h0) begin
			cnt_next = cnt_reg - 4'h1;
		end
	end

	// Pin registered from the next count, so low lasts exactly the count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 4'h0;
			pin_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			pin_reg <= pin_dis_next | (cnt_next == 4'h0); // [RQ8] [RQ9]
		end
	end

	assign frame_start_pin_n_o = pin_reg;

	// ==========================================
	// Interrupts
	assign frame_irq_o = flag_reg & irq_en_reg & ctrl_reg.chan_en; // [RQ5]
	assign ev = {art_ev, sof_ev, fs_set};

	// Read clears only the bits returned, so a late event survives
	generate
		for (genvar i = 0; i < 3; i++) begin : g_stat
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					stat_reg[i] <= 1'b0;
				end else if (ev[i]) begin
					stat_reg[i] <= 1'b1;
				end else if (rd_take & hit(idx, `FSEI_IDX_STAT) & dat_reg[i]) begin
					stat_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mask register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg <= `FSEI_RST3;
		end else if (wr_take & hit(idx, `FSEI_IDX_MASK)) begin
			mask_reg <= dat_i[2:0];
		end
	end

	assign irq_o = |(stat_reg & mask_reg);

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_pulse_go;
		fs_set && !pin_dis_next;
	endsequence

	sequence s_pulse_quiet;
		(!fs_set && !pin_dis_next) [*8];
	endsequence

	a_stamp_set: assert property (sof_ev |=> valid_reg) // [RQ1]
		else $error("stamp valid not set by token");
	a_stamp_clear: assert property (art_ev |=> !valid_reg) // [RQ1]
		else $error("stamp valid not cleared by artificial frame");
	a_flag_hw: assert property ((sof_ev || art_ev) |=> flag_reg) // [RQ2]
		else $error("frame flag not set on new frame");
	a_flag_fw: assert property (fw_set1 |=> flag_reg ##0 !frame_start_pin_n_o
		|| pin_dis_reg) // [RQ3]
		else $error("firmware set differs from hardware set");
	a_flag_selfclr: assert property (flag_reg && self_clr && !fs_set && !fw_set1
		|=> !flag_reg) // [RQ4]
		else $error("frame flag did not clear itself");
	a_flag_sticky: assert property (flag_reg && !self_clr && !fw_clr |=> flag_reg) // [RQ4]
		else $error("frame flag lost while firmware owns it");
	a_irq_gate: assert property (frame_irq_o |-> flag_reg && irq_en_reg
		&& ctrl_reg.chan_en) // [RQ5]
		else $error("frame interrupt without its conditions");
	a_irqen_owned: assert property (!hold_wr |=> $stable(irq_en_reg)) // [RQ6]
		else $error("interrupt enable changed without a write");
	a_lock_read: assert property (rd_take && hit(idx, `FSEI_IDX_FCHIGH)
		|-> dat_o[`FSEI_B_LOCK] == $past(locked_reg)) // [RQ7]
		else $error("lock bit read wrong");
	a_pin_disabled: assert property (pin_dis_reg |-> frame_start_pin_n_o) // [RQ8]
		else $error("pin low while output disabled");
	a_pin_low: assert property (s_pulse_go |=> !frame_start_pin_n_o [*8]) // [RQ9]
		else $error("pin pulse shorter than eight cycles");
	a_pin_end: assert property (s_pulse_go ##1 s_pulse_quiet
		|=> frame_start_pin_n_o) // [RQ9]
		else $error("pin pulse longer than eight cycles");
	a_ts_load: assert property (sof_ev |=> {ts_high_reg, ts_low_reg}
		== $past(sof_i.number)) // [RQ10] [RQ11]
		else $error("frame number not stored");
	a_ts_keep: assert property (art_ev && !wr_take |=> $stable(ts_low_reg)
		&& $stable(ts_high_reg)) // [RQ12]
		else $error("frame number changed on artificial frame");
	a_rsv_zero: assert property (rd_take && hit(idx, `FSEI_IDX_EPSEL)
		|-> dat_o[7:3] == 5'h0_0) // [RQ15]
		else $error("reserved index bits read nonzero");
	a_reset_zero: assert property ($past(rst_i) |-> ts_low_reg == `FSEI_RST8
		&& ts_high_reg == `FSEI_RST3 && ep_reg == `FSEI_RST3) // [RQ17]
		else $error("registers not cleared by reset");
	a_art_bound: assert property (art_ev |-> tmr_reg == PERIOD_LAST
		&& ft_reg == FT_RUN) // [RQ18]
		else $error("artificial frame off the boundary");

endmodule

// >>> verif/fsei_host_model.sv
// Host-side model that sends start-of-frame tokens
`timescale 1ns/1ps

module fsei_host_model
	import fsei_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Token request from the bench
	input wire logic go_i,
	input wire logic [10:0] num_i,
	input wire logic [7:0] dly_i,
	// Token to the device
	output fsei_sof_type sof_o
);
	logic busy_reg;
	logic [7:0] cnt_reg;
	logic [10:0] num_reg;

	// ==========================================
	// Token timing: prompt (delay 0) or slow
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_reg <= 1'b0;
			cnt_reg <= 8'h00;
			num_reg <= 11'h000;
			sof_o <= '0;
		end else begin
			sof_o.valid <= 1'b0;
			// Number is meaningless between tokens, so keep it moving
			sof_o.number <= ~sof_o.number;
			if (go_i) begin
				busy_reg <= 1'b1;
				cnt_reg <= dly_i;
				num_reg <= num_i;
			end else if (busy_reg && cnt_reg == 8'h00) begin
				busy_reg <= 1'b0;
				sof_o.valid <= 1'b1;
				sof_o.number <= num_reg;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end
endmodule

// >>> verif/test_fsei_top.sv
// Self-checking bench for the frame stamp and endpoint index block
`timescale 1ns/1ps

module test_fsei_top;
	import fsei_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, go, frame_start_pin_n_o, frame_irq_o, irq_o, ack_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [2:0] endpoint_index_field_o;
	logic [10:0] num;
	fsei_sof_type sof;
	int miscompares = 0;
	int tests_run = 0;

	// ==========================================
	// Device and host model
	fsei_top #(.FRAME_CYCLES(200)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .sof_i(sof), .frame_start_pin_n_o(frame_start_pin_n_o),
		.frame_irq_o(frame_irq_o), .irq_o(irq_o),
		.endpoint_index_field_o(endpoint_index_field_o));
	fsei_host_model host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .num_i(num),
		.dly_i(8'h03), .sof_o(sof));

	// ==========================================
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle; waits for ack with no assumed latency
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h00_0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	// One token; returns at the edge that takes it
	task automatic token(input logic [10:0] n);
		@(posedge clk_i);
		go <= 1'b1;
		num <= n;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (20) if (sof.valid !== 1'b1) @(posedge clk_i);
	endtask

	// Pin level for a span of cycles after a flag set
	task automatic pin_span(input int n, input logic lvl);
		repeat (n) begin
			@(negedge clk_i);
			cmp({31'h0, frame_start_pin_n_o}, {31'h0, lvl});
		end
	endtask

	task automatic t_reset;
		bus(1'b0, 8'h28, 8'h00);
		cmp(rd, 32'h0000_0000);
		bus(1'b0, 8'h38, 8'h00);
		cmp(rd, 32'h0000_0000);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd, 32'h0000_0000);
		cmp({29'h0, frame_start_pin_n_o, irq_o, frame_irq_o}, 32'h0000_0004);
		$display("reset test done");
	endtask

	task automatic t_index;
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 8'h28, 8'(i));
			bus(1'b0, 8'h28, 8'h00);
			cmp(rd, 32'(i));
			cmp({29'h0, endpoint_index_field_o}, 32'(i));
		end
		bus(1'b0, 8'h04, 8'h00);
		cmp(rd, 32'h0000_0000);
		$display("index test done");
	endtask

	task automatic t_token;
		token(11'h5a3);
		pin_span(8, 1'b0);
		pin_span(1, 1'b1);
		bus(1'b0, 8'h38, 8'h00);
		cmp(rd, 32'h0000_00a3);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd & 32'h0000_00ef, 32'h0000_0085);
		bus(1'b1, 8'h3c, 8'h45);
		pin_span(8, 1'b0);
		pin_span(1, 1'b1);
		$display("token test done");
	endtask

	task automatic t_lock;
		repeat (150) @(posedge clk_i);
		token(11'h2c7);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd & 32'h0000_0097, 32'h0000_0092);
		repeat (230) @(posedge clk_i);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd, 32'h0000_0002);
		bus(1'b0, 8'h38, 8'h00);
		cmp(rd, 32'h0000_00c7);
		bus(1'b0, 8'h44, 8'h00);
		cmp(rd & 32'h0000_0005, 32'h0000_0005);
		$display("lock test done");
	endtask

	task automatic t_irq;
		bus(1'b1, 8'h40, 8'h04);
		bus(1'b1, 8'h3c, 8'h28);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd & 32'h0000_0028, 32'h0000_0000);
		bus(1'b1, 8'h40, 8'h06);
		bus(1'b1, 8'h3c, 8'h68);
		pin_span(10, 1'b1);
		cmp({31'h0, frame_irq_o}, 32'h0000_0001);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd & 32'h0000_0068, 32'h0000_0068);
		bus(1'b1, 8'h40, 8'h02);
		@(negedge clk_i);
		cmp({31'h0, frame_irq_o}, 32'h0000_0000);
		bus(1'b1, 8'h48, 8'h02);
		bus(1'b0, 8'h44, 8'h00);
		token(11'h011);
		@(negedge clk_i);
		cmp({31'h0, irq_o}, 32'h0000_0001);
		bus(1'b0, 8'h44, 8'h00);
		cmp(rd & 32'h0000_0002, 32'h0000_0002);
		@(negedge clk_i);
		cmp({31'h0, irq_o}, 32'h0000_0000);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd & 32'h0000_0020, 32'h0000_0020);
		$display("interrupt test done");
	endtask

	// Feature mode keeps the flag until firmware clears it
	task automatic t_feature;
		bus(1'b1, 8'h40, 8'h03);
		bus(1'b1, 8'h3c, 8'h00);
		token(11'h123);
		pin_span(8, 1'b0);
		pin_span(1, 1'b1);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd & 32'h0000_00c7, 32'h0000_00c1);
		bus(1'b1, 8'h3c, 8'h00);
		bus(1'b0, 8'h3c, 8'h00);
		cmp(rd & 32'h0000_0040, 32'h0000_0000);
		bus(1'b1, 8'h40, 8'h00);
		$display("feature test done");
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================
	// Watchdog, well above the several hundred cycles needed
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end

	// ==========================================
	// Main sequence
	initial begin
		{rst_i, cyc_i, stb_i, we_i, go} = 5'b10000;
		adr_i = 8'h00;
		sel_i = 4'h1;
		dat_i = 32'h0000_0000;
		num = 11'h000;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_index();
		t_token();
		t_lock();
		t_irq();
		t_feature();
		wrap_up();
	end
endmodule
